// *** rtl/charger_pkg.sv ***
// Shared constants and carrier types for the charger switch control core.
package charger_pkg;

  // Clock period of mclk_i in picoseconds (100 MHz).
  localparam int CLK_PERIOD_PS = 10000;

  // Break-before-make delay between source-off and load-on, in ps.
  localparam int BBM_TIME_PS = 7500000;
  // Least time, rounded up to whole cycles.
  localparam int BBM_CYCLES = (BBM_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Minimum off-time of the high-side switch, in ps.
  localparam int MIN_OFF_PS = 300000;
  localparam int MIN_OFF_CYCLES =
    (MIN_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Fixed off-time used in dropout, in ps.
  localparam int DROP_OFF_PS = 270000;
  localparam int DROP_OFF_CYCLES =
    (DROP_OFF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Charge safety timeout in seconds and its cycle count.
  localparam longint TIMEOUT_S = 175;
  localparam longint TIMEOUT_CYCLES =
    TIMEOUT_S * 64'd1000000000000 / CLK_PERIOD_PS;

  // Edges after reset before the settled pin values are first used; the
  // value flop behind the three-stage synchroniser is valid after four.
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  // Command codes seen on the decoded command port.
  localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;
  localparam logic [7:0] CMD_CURRENT_SET = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE_SET = 8'h15;
  localparam logic [7:0] CMD_MODE = 8'h12;

  // Field layout of the input-limit command.
  localparam int LIMIT_LSB = 7;
  localparam int LIMIT_MSB = 12;
  localparam logic [5:0] LIMIT_RESET = 6'h00;

  // Bit of the mode command that requests a power-on reset.
  localparam int MODE_POR_BIT = 10;

  // Comparator and thermistor inputs, all asynchronous to mclk_i.
  typedef struct packed {
    logic adapter;      // Adapter-detect comparator, high when present.
    logic headroom_ok;  // Input minus battery is at least 100 mV.
    logic floor_ok;     // Control signal above its floor.
    logic peak;         // Current feedback above the control point.
    logic limit;        // Cycle-by-cycle current limit reached.
    logic zero;         // Inductor current has fallen to zero.
    logic dropout;      // Battery at or above 0.88 of input.
    logic th_over;      // Thermistor overrange, no battery.
    logic th_hot;       // Thermistor hot.
    logic th_under;     // Thermistor underrange.
  } sense_t;

  // One decoded command write from the serial interface.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_t;

  // Power-path states, Gray coded along adapter, removal, battery.
  typedef enum logic [2:0] {
    P_RESET = 3'h0,
    P_ADAPTER = 3'h1,
    P_BBM = 3'h3,
    P_BATTERY = 3'h2,
    P_DOWN = 3'h6
  } path_state_t;

  // Converter states, Gray coded along the switching cycle.
  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_ON = 2'h1,
    C_OFF = 2'h3,
    C_WAIT = 2'h2
  } conv_state_t;

endpackage

// *** rtl/charger_switch_control.sv ***
// Switch, power-path and charge gating control core of the charger.
module charger_switch_control #(
  parameter int OFF_W = 16,
  parameter longint TIMEOUT_CYCLES = charger_pkg::TIMEOUT_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire charger_pkg::sense_t sense_i,
  input wire charger_pkg::cmd_t cmd_i,
  input wire logic [OFF_W-1:0] off_time_i,
  output logic hs_en_o,
  output logic ls_en_o,
  output logic source_path_drive_o,
  output logic load_path_drive_o,
  output logic adapter_present_out_o,
  output logic adapter_present_oe_n_o,
  output logic power_down_o,
  output logic charge_enable_o,
  output logic hot_latched_o,
  output logic timed_out_o,
  output logic [5:0] input_limit_code_o
);

  localparam int SW = $bits(charger_pkg::sense_t);

  // The off counter must hold the fixed off-times; the timer has 41 bits.
  if (OFF_W < 8 || TIMEOUT_CYCLES < 1 ||
      TIMEOUT_CYCLES > 64'h0000_01FF_FFFF_FFFF) begin : g_param_check
    $error("OFF_W or TIMEOUT_CYCLES out of range.");
  end
  // The break-before-make counter is sized for its fixed figure.
  if (charger_pkg::BBM_CYCLES > 1023) begin : g_bbm_check
    $error("Break-before-make count exceeds its counter.");
  end

  // Three-stage synchronisers and the filtered, settled values.
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [SW-1:0] sync3;
  logic [SW-1:0] sense_q;
  charger_pkg::sense_t sn;

  // Each comparator passes three flops; a change counts when two agree.
  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        sense_q[i] <= 1'b0;
      end else begin
        sync1[i] <= sense_i[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          sense_q[i] <= sync3[i];
        end
      end
    end
  end
  assign sn = charger_pkg::sense_t'(sense_q);

  // Settle counter: the path stays on battery until inputs are valid.
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic settled;

  // Settle count advances until it reaches its end and then holds.
  always_comb begin
    settled = (settle == charger_pkg::SETTLE_CYCLES);
    next_settle = settled ? settle : settle + 3'h1;
  end

  // Power path state, its counter and the registered drives.
  charger_pkg::path_state_t path;
  charger_pkg::path_state_t next_path;
  logic [9:0] bbm_cnt;
  logic [9:0] next_bbm_cnt;
  logic next_src;
  logic next_load;
  logic next_pd;
  logic next_present;

  // Path selection with break-before-make on adapter removal.
  always_comb begin
    next_path = path;
    next_bbm_cnt = bbm_cnt;
    case (path)
      charger_pkg::P_RESET: begin
        // Hold the battery-powered state until the inputs are sampled.
        if (settled) begin
          if (!sn.headroom_ok) begin
            next_path = charger_pkg::P_DOWN;
          end else if (sn.adapter) begin
            next_path = charger_pkg::P_ADAPTER;
          end else begin
            next_path = charger_pkg::P_BATTERY;
          end
        end
      end
      charger_pkg::P_ADAPTER: begin
        if (!sn.headroom_ok) begin
          next_path = charger_pkg::P_DOWN;
        end else if (!sn.adapter) begin
          // Source begins to turn off now; load waits out the delay.
          next_path = charger_pkg::P_BBM;
          next_bbm_cnt = 10'(charger_pkg::BBM_CYCLES - 1);
        end
      end
      charger_pkg::P_BBM: begin
        if (bbm_cnt == 10'h000) begin
          next_path = charger_pkg::P_BATTERY;
        end else begin
          next_bbm_cnt = bbm_cnt - 10'h001;
        end
      end
      charger_pkg::P_BATTERY: begin
        if (sn.adapter && sn.headroom_ok) begin
          next_path = charger_pkg::P_ADAPTER;
        end
      end
      default: begin
        // Powered down; recover once headroom returns, to the adapter path if one is present, else to battery.
        if (sn.headroom_ok) begin
          next_path = sn.adapter ? charger_pkg::P_ADAPTER
                                 : charger_pkg::P_BATTERY;
        end
      end
    endcase
    // Drives follow the next state so they leave flops directly.
    next_src = (next_path == charger_pkg::P_ADAPTER);
    next_load = (next_path == charger_pkg::P_BATTERY) ||
                (next_path == charger_pkg::P_RESET) ||
                (next_path == charger_pkg::P_DOWN);
    next_pd = (next_path == charger_pkg::P_DOWN);
    next_present = (next_path == charger_pkg::P_ADAPTER) ||
                   ((next_path != charger_pkg::P_RESET) && sn.adapter);
  end

  // Registers of the path group.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      settle <= 3'h0;
      path <= charger_pkg::P_RESET;
      bbm_cnt <= 10'h000;
      source_path_drive_o <= 1'b0;
      load_path_drive_o <= 1'b1;
      power_down_o <= 1'b0;
      adapter_present_out_o <= 1'b0;
      adapter_present_oe_n_o <= 1'b0;
    end else begin
      settle <= next_settle;
      path <= next_path;
      bbm_cnt <= next_bbm_cnt;
      source_path_drive_o <= next_src;
      load_path_drive_o <= next_load;
      power_down_o <= next_pd;
      // Open drain: released (enable high) while an adapter is present.
      adapter_present_out_o <= 1'b0;
      adapter_present_oe_n_o <= next_present;
    end
  end

  // Command, thermistor and timeout state.
  logic [5:0] next_limit;
  logic next_hot;
  logic [40:0] tmo_cnt;
  logic [40:0] next_tmo_cnt;
  logic next_timed_out;
  logic next_charge;
  logic setpoint_cmd;
  logic por_cmd;

  // Decode commands, latch the hot flag and run the safety timer.
  always_comb begin
    next_limit = input_limit_code_o;
    if (cmd_i.valid && (cmd_i.code == charger_pkg::CMD_INPUT_LIMIT)) begin
      // Only the six weighted bits are kept; the rest are ignored.
      next_limit =
        cmd_i.data[charger_pkg::LIMIT_MSB:charger_pkg::LIMIT_LSB];
    end
    setpoint_cmd = cmd_i.valid &&
                   ((cmd_i.code == charger_pkg::CMD_CURRENT_SET) ||
                    (cmd_i.code == charger_pkg::CMD_VOLTAGE_SET));
    por_cmd = cmd_i.valid && (cmd_i.code == charger_pkg::CMD_MODE) &&
              cmd_i.data[charger_pkg::MODE_POR_BIT];
    // Hot latches; battery removal or reset request clears; set wins.
    if (sn.th_hot) begin
      next_hot = 1'b1;
    end else if (sn.th_over || por_cmd) begin
      next_hot = 1'b0;
    end else begin
      next_hot = hot_latched_o;
    end
    // Each setpoint command restarts the timer.
    if (setpoint_cmd) begin
      next_tmo_cnt = 41'h0;
      next_timed_out = 1'b0;
    end else if (tmo_cnt >= 41'(TIMEOUT_CYCLES - 1)) begin
      next_tmo_cnt = tmo_cnt;
      next_timed_out = 1'b1;
    end else begin
      next_tmo_cnt = tmo_cnt + 41'h1;
      next_timed_out = timed_out_o;
    end
    // Underrange always allows; overrange and hot forbid; cold and
    // normal allow only while the timeout has not run out.
    next_charge = (next_path == charger_pkg::P_ADAPTER) &&
                  (sn.th_under ||
                   (!sn.th_over && !next_hot && !next_timed_out));
  end

  // Registers of the command group.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      input_limit_code_o <= charger_pkg::LIMIT_RESET;
      hot_latched_o <= 1'b0;
      tmo_cnt <= 41'h0;
      timed_out_o <= 1'b0;
      charge_enable_o <= 1'b0;
    end else begin
      input_limit_code_o <= next_limit;
      hot_latched_o <= next_hot;
      tmo_cnt <= next_tmo_cnt;
      timed_out_o <= next_timed_out;
      charge_enable_o <= next_charge;
    end
  end

  // Converter state, off-time counter and switch enables.
  charger_pkg::conv_state_t conv;
  charger_pkg::conv_state_t next_conv;
  logic [OFF_W-1:0] off_cnt;
  logic [OFF_W-1:0] next_off_cnt;
  logic [OFF_W-1:0] off_load;
  logic next_hs;
  logic next_ls;
  logic may_start;

  // Constant off-time current-mode switching cycle.
  always_comb begin
    next_conv = conv;
    next_off_cnt = off_cnt;
    next_hs = 1'b0;
    next_ls = 1'b0;
    // Dropout uses the fixed time, else the supplied count.
    off_load = sn.dropout ? OFF_W'(charger_pkg::DROP_OFF_CYCLES)
                          : off_time_i;
    // Never shorter than the minimum off interval.
    if (off_load < OFF_W'(charger_pkg::MIN_OFF_CYCLES)) begin
      off_load = OFF_W'(charger_pkg::MIN_OFF_CYCLES);
    end
    may_start = sn.floor_ok && !sn.limit;
    if (!charge_enable_o) begin
      // Not charging: both switches off, but the off interval still runs.
      next_conv = (conv == charger_pkg::C_ON) ? charger_pkg::C_OFF :
                  (conv == charger_pkg::C_OFF && off_cnt != '0) ?
                  charger_pkg::C_OFF : charger_pkg::C_IDLE;
      if (conv == charger_pkg::C_ON) begin
        next_off_cnt = off_load - OFF_W'(1);
      end else if (off_cnt != '0) begin
        next_off_cnt = off_cnt - OFF_W'(1);
      end
    end else begin
      case (conv)
        charger_pkg::C_ON: begin
          next_hs = 1'b1;
          if (sn.peak || sn.limit) begin
            // End the on-time at once; start the off interval.
            next_conv = charger_pkg::C_OFF;
            next_off_cnt = off_load - OFF_W'(1);
            next_hs = 1'b0;
            next_ls = !sn.zero;
          end
        end
        charger_pkg::C_OFF: begin
          next_ls = !sn.zero;
          if (off_cnt != '0) begin
            next_off_cnt = off_cnt - OFF_W'(1);
          end else if (may_start) begin
            next_conv = charger_pkg::C_ON;
            next_hs = 1'b1;
            next_ls = 1'b0;
          end else begin
            next_conv = charger_pkg::C_WAIT;
          end
        end
        default: begin
          // Waiting: low side stays on only until zero current is seen; idle: low side off.
          next_ls = (conv == charger_pkg::C_WAIT) && !sn.zero &&
                    ls_en_o;
          if (may_start) begin
            next_conv = charger_pkg::C_ON;
            next_hs = 1'b1;
            next_ls = 1'b0;
          end
        end
      endcase
    end
  end

  // Registers of the converter group; switches start off.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      conv <= charger_pkg::C_IDLE;
      off_cnt <= '0;
      hs_en_o <= 1'b0;
      ls_en_o <= 1'b0;
    end else begin
      conv <= next_conv;
      off_cnt <= next_off_cnt;
      hs_en_o <= next_hs;
      ls_en_o <= next_ls;
    end
  end

endmodule

// *** tb/charger_switch_control_props.sv ***
// Checker for switch, path, command and gating behaviour of the core.
module charger_switch_control_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire charger_pkg::sense_t sense_i,
  input wire charger_pkg::cmd_t cmd_i,
  input wire logic hs_en_o,
  input wire logic ls_en_o,
  input wire logic source_path_drive_o,
  input wire logic load_path_drive_o,
  input wire logic adapter_present_out_o,
  input wire logic adapter_present_oe_n_o,
  input wire logic power_down_o,
  input wire logic charge_enable_o,
  input wire logic timed_out_o,
  input wire logic [5:0] input_limit_code_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Low cycles of the high side, and cycles since the source drive fell.
  logic [7:0] low_n, next_low_n;
  logic [9:0] bbm_n, next_bbm_n;
  logic src_q, next_src_q;
  logic is_lim, is_set;
  assign is_lim = cmd_i.valid && cmd_i.code == charger_pkg::CMD_INPUT_LIMIT;
  assign is_set = cmd_i.valid && (cmd_i.code == charger_pkg::CMD_CURRENT_SET
    || cmd_i.code == charger_pkg::CMD_VOLTAGE_SET);
  // Next counts; the low count saturates so long waits cannot wrap.
  always_comb begin
    next_src_q = source_path_drive_o;
    next_low_n = hs_en_o ? 8'h00 : low_n + 8'(low_n != 8'hFF);
    next_bbm_n = 10'h000;
    if (src_q && !source_path_drive_o) begin
      next_bbm_n = 10'h001;
    end else if (bbm_n != 10'h000 && !load_path_drive_o) begin
      next_bbm_n = bbm_n + 10'h001;
    end
  end
  // Registers the counts; reset counts as a long off interval.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      low_n <= 8'hFF;
      bbm_n <= 10'h000;
      src_q <= 1'b0;
    end else begin
      low_n <= next_low_n;
      bbm_n <= next_bbm_n;
      src_q <= next_src_q;
    end
  end
  sequence s_limit_held; sense_i.limit [*7]; endsequence
  sequence s_floor_low; !sense_i.floor_ok [*7]; endsequence
  sequence s_zero_held; sense_i.zero [*7]; endsequence
  sequence s_over_held; (sense_i.th_over && !sense_i.th_under) [*7];
  endsequence
  a_no_overlap: assert property (!(hs_en_o && ls_en_o))
    else $error("both switches on");
  a_min_off: assert property ($rose(hs_en_o) |->
    low_n >= 8'(charger_pkg::MIN_OFF_CYCLES)) else $error("off time short");
  a_peak_ends: assert property (
    hs_en_o && (sense_i.peak || sense_i.limit) |-> ##[1:7] !hs_en_o)
    else $error("on-time not ended");
  a_limit_blocks: assert property (s_limit_held |-> !$rose(hs_en_o))
    else $error("start under current limit");
  a_floor_blocks: assert property (s_floor_low |-> !$rose(hs_en_o))
    else $error("start under low floor");
  a_zero_hold: assert property (s_zero_held |-> !ls_en_o)
    else $error("low side on at zero current");
  a_bbm_delay: assert property ($rose(load_path_drive_o) &&
    !power_down_o |-> bbm_n == 10'(charger_pkg::BBM_CYCLES))
    else $error("break before make delay wrong");
  a_source_path: assert property (source_path_drive_o |->
    !load_path_drive_o && adapter_present_oe_n_o && !adapter_present_out_o)
    else $error("adapter path drives wrong");
  a_power_down: assert property (power_down_o |->
    !source_path_drive_o && load_path_drive_o) else $error("power down");
  a_limit_code: assert property (is_lim |=>
    input_limit_code_o == $past(cmd_i.data[12:7])) else $error("limit code");
  a_timer_clear: assert property (is_set |=> !timed_out_o)
    else $error("timer not restarted");
  a_over_stops: assert property (s_over_held |-> !charge_enable_o)
    else $error("charging in overrange");
endmodule
bind charger_switch_control charger_switch_control_props u_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .sense_i(sense_i), .cmd_i(cmd_i),
  .hs_en_o(hs_en_o), .ls_en_o(ls_en_o),
  .source_path_drive_o(source_path_drive_o),
  .load_path_drive_o(load_path_drive_o),
  .adapter_present_out_o(adapter_present_out_o),
  .adapter_present_oe_n_o(adapter_present_oe_n_o),
  .power_down_o(power_down_o), .charge_enable_o(charge_enable_o),
  .timed_out_o(timed_out_o), .input_limit_code_o(input_limit_code_o));

// *** tb/switch_stage_model.sv ***
// Behavioural switch stage: inductor current that follows the switches.
module switch_stage_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hs_en_i,
  input wire logic ls_en_i,
  input wire logic [7:0] peak_lvl_i,
  output logic peak_o,
  output logic zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Current in steps; a low peak level answers fast, a high one slowly.
  logic [7:0] cur;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= 8'h00;
    end else if (hs_en_i) begin
      cur <= cur + 8'h01;
    end else if (ls_en_i && cur != 8'h00) begin
      cur <= cur - 8'h01;
    end
  end
  // The comparators have no delay of their own.
  assign peak_o = cur >= peak_lvl_i;
  assign zero_o = cur == 8'h00;
endmodule

// *** tb/tb_charger_switch_control.sv ***
// Self-checking bench for the charger switch control core.
module tb_charger_switch_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint TOUT = 2000;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  charger_pkg::sense_t drv = '{headroom_ok: 1'b1, default: 1'b0};
  charger_pkg::sense_t sense;
  charger_pkg::cmd_t cmd = '0;
  logic [15:0] off_q = 16'h0020;
  logic [7:0] pk_lvl = 8'h10;
  logic hs, ls, src, load, od, oe_n, pd, chg, hot, tmo, pk, zr;
  logic [5:0] code;
  int n_fail = 0, comparisons = 0, cycles = 0;
  int low_n = 0, last_off = 0, n_starts = 0;
  always #5 mclk_i = ~mclk_i;
  // Peak and zero come from the switch stage model.
  always_comb begin
    sense = drv;
    sense.peak = pk;
    sense.zero = zr;
  end
  charger_switch_control #(.OFF_W(16), .TIMEOUT_CYCLES(TOUT)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .sense_i(sense), .cmd_i(cmd),
    .off_time_i(off_q), .hs_en_o(hs), .ls_en_o(ls),
    .source_path_drive_o(src), .load_path_drive_o(load),
    .adapter_present_out_o(od), .adapter_present_oe_n_o(oe_n),
    .power_down_o(pd), .charge_enable_o(chg), .hot_latched_o(hot),
    .timed_out_o(tmo), .input_limit_code_o(code));
  switch_stage_model stage (.mclk_i(mclk_i), .rst_i(rst_i), .hs_en_i(hs),
    .ls_en_i(ls), .peak_lvl_i(pk_lvl), .peak_o(pk), .zero_o(zr));
  // Measures each low interval of the high side; also cuts a hang short.
  always @(posedge mclk_i) begin
    cycles++;
    if (hs === 1'b1 && low_n > 0) begin
      last_off = low_n;
      n_starts++;
    end
    low_n = (hs === 1'b1) ? 0 : low_n + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command pulse; returns at the negedge after it was taken.
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk_i);
    cmd <= '{1'b1, c, d};
    @(posedge mclk_i);
    cmd.valid <= 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // Off interval: fixed in dropout, never under the minimum.
  function automatic logic [15:0] exp_off(input int n, input logic d);
    int t;
    t = d ? charger_pkg::DROP_OFF_CYCLES : n;
    if (t < charger_pkg::MIN_OFF_CYCLES) begin
      t = charger_pkg::MIN_OFF_CYCLES;
    end
    return 16'(t);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    int ot;
    int s0;
    logic [15:0] d;
    void'($urandom(37));
    wt(2);
    @(negedge mclk_i);
    chk("reset drives", 16'h0002, 16'({hs, ls, src, load, oe_n}));
    @(posedge mclk_i);
    rst_i <= 1'b0;
    wt(1);
    drv.adapter <= 1'b1;
    wt(10);
    @(negedge mclk_i);
    chk("adapter path", 16'h000A, 16'({src, load, oe_n, od}));
    done("adapter");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hE07F : (i == 1) ? 16'h1F80 : 16'($urandom);
      send(charger_pkg::CMD_INPUT_LIMIT, d);
      chk("limit code", 16'(d[12:7]), 16'(code));
    end
    send(8'h55, 16'hFFFF);
    chk("limit kept", 16'(d[12:7]), 16'(code));
    done("limit");
    for (int k = 0; k < 3; k++) begin
      send(charger_pkg::CMD_CURRENT_SET, 16'h0000);
      wt(1);
      ot = 10 + $urandom % 51;
      off_q <= 16'(ot);
      pk_lvl <= 8'(4 + $urandom % 40);
      drv.dropout <= (k == 2);
      drv.floor_ok <= 1'b1;
      wt(300);
      s0 = n_starts;
      wt(200);
      @(negedge mclk_i);
      chk("cycles ran", 16'h0001, 16'(n_starts > s0));
      chk("off time", exp_off(ot, k == 2), 16'(last_off));
      done("converter");
    end
    for (int k = 0; k < 2; k++) begin
      wt(1);
      drv.floor_ok <= (k == 1);
      drv.limit <= (k == 1);
      wt(20);
      s0 = n_starts;
      wt(150);
      @(negedge mclk_i);
      chk("blocked starts", 16'(s0), 16'(n_starts));
    end
    wt(1);
    drv.limit <= 1'b0;
    done("blocking");
    send(charger_pkg::CMD_CURRENT_SET, 16'h0000);
    wt(1);
    drv.th_hot <= 1'b1;
    wt(8);
    drv.th_hot <= 1'b0;
    wt(8);
    @(negedge mclk_i);
    chk("hot latched", 16'h0002, 16'({hot, chg}));
    wt(1);
    drv.th_under <= 1'b1;
    wt(8);
    @(negedge mclk_i);
    chk("underrange", 16'h0001, 16'(chg));
    wt(1);
    drv.th_under <= 1'b0;
    send(charger_pkg::CMD_MODE, 16'(1 << charger_pkg::MODE_POR_BIT));
    wt(8);
    @(negedge mclk_i);
    chk("hot cleared", 16'h0000, 16'(hot));
    wt(1);
    drv.th_over <= 1'b1;
    wt(8);
    @(negedge mclk_i);
    chk("overrange", 16'h0000, 16'(chg));
    wt(1);
    drv.th_over <= 1'b0;
    done("thermistor");
    send(charger_pkg::CMD_VOLTAGE_SET, 16'h0000);
    wt(int'(TOUT) + 20);
    @(negedge mclk_i);
    chk("timer expired", 16'h0002, 16'({tmo, chg}));
    send(charger_pkg::CMD_VOLTAGE_SET, 16'h1000);
    chk("timer restart", 16'h0000, 16'(tmo));
    done("timer");
    wt(1);
    drv.adapter <= 1'b0;
    s0 = 0;
    while (src !== 1'b0 && s0 < 20) begin
      @(negedge mclk_i);
      s0++;
    end
    chk("adapter gone", 16'h0000, 16'({src, oe_n}));
    s0 = 0;
    while (load !== 1'b1 && s0 < 2000) begin
      @(negedge mclk_i);
      s0++;
    end
    chk("break before make", 16'(charger_pkg::BBM_CYCLES), 16'(s0));
    wt(1);
    drv.adapter <= 1'b1;
    wt(10);
    drv.headroom_ok <= 1'b0;
    wt(10);
    @(negedge mclk_i);
    chk("power down", 16'h0005, 16'({pd, src, load}));
    done("paths");
    give_verdict();
  end
endmodule
